//--- design/ctep_buf2.sv
// small ring buffer with valid and ready on both sides
`timescale 1ns/1ns
module ctep_buf2 #(
    parameter int W = 9,
    parameter int D = 2
) (
    input  wire logic         clock,
    input  wire logic         nrst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       rd;
        logic [AW-1:0]       wr;
        logic [CW-1:0]       cnt;
    } ctep_buf_s;

    ctep_buf_s r;
    ctep_buf_s n;
    logic      push;
    logic      pop;

    // full and empty come straight from the count
    assign in_ready  = (r.cnt != CW'(D));
    assign out_valid = (r.cnt != '0);
    assign out_data  = r.mem[r.rd];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // pointers wrap at depth so any depth works
    always_comb begin
        n = r;
        if (push) begin
            n.mem[r.wr] = in_data;
            n.wr = (r.wr == AW'(D - 1)) ? '0 : r.wr + 1'b1;
        end
        if (pop) begin
            n.rd = (r.rd == AW'(D - 1)) ? '0 : r.rd + 1'b1;
        end
        case ({push, pop})
            2'b10:   n.cnt = r.cnt + 1'b1;
            2'b01:   n.cnt = r.cnt - 1'b1;
            default: n.cnt = r.cnt;
        endcase
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
endmodule

//--- design/ctep_pkg.sv
// shared constants and types of the channel end token port
package ctep_pkg;
    // thread-side operation codes
    typedef enum logic [3:0] {
        OP_OUT_BYTE  = 4'h0,
        OP_OUT_WORD  = 4'h1,
        OP_OUT_CT    = 4'h2,
        OP_IN_BYTE   = 4'h3,
        OP_IN_WORD   = 4'h4,
        OP_IN_CT     = 4'h5,
        OP_CHK_CT    = 4'h6,
        OP_TEST_CT   = 4'h7,
        OP_TEST_WCT  = 4'h8,
        OP_ST_MASTER = 4'h9,
        OP_ST_SLAVE  = 4'hA,
        OP_SP_MASTER = 4'hB,
        OP_SP_SLAVE  = 4'hC,
        OP_BLK_OUT   = 4'hD,
        OP_BLK_IN    = 4'hE,
        OP_MSG_END   = 4'hF
    } ctep_op_e;

    // gray along idle, exec, send
    typedef enum logic [1:0] {
        S_IDLE = 2'h0,
        S_EXEC = 2'h1,
        S_SEND = 2'h3
    } ctep_state_e;

    // streaming route state
    typedef enum logic [1:0] {
        R_CLOSED = 2'h0,
        R_OPEN   = 2'h1
    } ctep_route_e;

    localparam logic [7:0] end_of_message_token = 8'h01;
    localparam logic [7:0] route_pause_token    = 8'h02;
    localparam logic [7:0] HW_TOKEN_MIN         = 8'hC0;
    localparam logic [2:0] WORD_BYTES           = 3'h4;
    localparam logic [2:0] ONE_BYTE             = 3'h1;
    localparam int         BLK_W                = 16;
    localparam int         TOK_W                = 9;
    localparam int         BUF_DEPTH            = 2;
endpackage

//--- design/ctep_port.sv
// channel end: tagged token queue, streaming route, thread ops
`timescale 1ns/1ns
// Function
// - byte input with control token at head raises exception
// - word input with control token in its bytes raises exception
// - sending a reserved hardware control token raises exception
// - check token drops matching head token, else exception
// - control token input returns and drops head token, data excepts
// - byte test returns 1 for control head, 0 otherwise, no drop
// - word test returns first control position 1 to 4, else 0
// - master and slave starts pair and hold a route open
// - matching stops tear the route down and release it
// - with every path held, other channel traffic is blocked
// - slave start in a select is ready once master starts
// - word input in a select is ready when any data waits
// - block transfer sends and receives exactly the given count
// - raw streamed framing never mixes with message transfers
// - each tile has a network-unique readable identifier
// - each logical core has a tile-unique readable identifier
module ctep_port #(
    parameter logic [15:0] TILE_ID = 16'h0000,
    parameter logic [7:0]  CORE_ID = 8'h00
) (
    input  wire logic        clock,
    input  wire logic        nrst,
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  ctep_pkg::ctep_op_e cmd_op,
    input  wire logic [31:0] cmd_data,
    output logic             rsp_valid,
    output logic             rsp_exc,
    output logic [31:0]      rsp_data,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    output logic             tx_ctrl,
    output logic [7:0]       tx_byte,
    input  wire logic        rx_valid,
    output logic             rx_ready,
    input  wire logic        rx_ctrl,
    input  wire logic [7:0]  rx_byte,
    input  wire logic        paths_free,
    input  wire logic        peer_route_req,
    output logic             route_hold,
    output logic             start_ready,
    output logic             word_ready,
    output logic [15:0]      tile_id,
    output logic [7:0]       core_id
);
    typedef struct packed {
        ctep_pkg::ctep_state_e      state;
        ctep_pkg::ctep_op_e         op;
        logic [31:0]                arg;
        logic [31:0]                tx_sh;
        logic                       tx_ctl;
        logic [2:0]                 tx_left;
        logic [3:0][7:0]            q_byte;
        logic [3:0]                 q_tag;
        logic [2:0]                 q_cnt;
        ctep_pkg::ctep_route_e      route;
        logic                       role_slave;
        logic [ctep_pkg::BLK_W-1:0] blk_left;
        logic                       blk_in;
        logic                       rsp_valid;
        logic                       rsp_exc;
        logic [31:0]                rsp_data;
    } ctep_port_s;

    ctep_port_s r;
    ctep_port_s n;
    logic       buf_valid;
    logic       buf_ready;
    logic [8:0] buf_tok;
    logic       tx_fire;
    logic [2:0] ct_pos;
    logic       blk_ok;
    logic       done;
    logic       exc;
    logic [31:0] dat;
    logic [2:0] pop_n;
    logic       open;
    logic       have1;
    logic       have4;
    int         j;

    // link bytes land in a two-entry buffer so a stalled gather loses none
    ctep_buf2 #(
        .W (ctep_pkg::TOK_W),
        .D (ctep_pkg::BUF_DEPTH)
    ) u_rxbuf (
        .clock     (clock),
        .nrst      (nrst),
        .in_valid  (rx_valid),
        .in_ready  (rx_ready),
        .in_data   ({rx_ctrl, rx_byte}),
        .out_valid (buf_valid),
        .out_ready (buf_ready),
        .out_data  (buf_tok)
    );

    // handshakes are combinational, data from flops
    assign cmd_ready  = (r.state == ctep_pkg::S_IDLE);
    assign open       = (r.route == ctep_pkg::R_OPEN);
    assign tx_valid   = (r.state == ctep_pkg::S_SEND) && (open || paths_free);
    assign tx_fire    = tx_valid && tx_ready;
    assign tx_ctrl    = r.tx_ctl;
    assign tx_byte    = r.tx_sh[31:24];
    assign rsp_valid  = r.rsp_valid;
    assign rsp_exc    = r.rsp_exc;
    assign rsp_data   = r.rsp_data;
    assign route_hold = open;
    assign start_ready = !open && peer_route_req;
    assign word_ready = (r.q_cnt != '0) || buf_valid;
    assign tile_id    = TILE_ID;
    assign core_id    = CORE_ID;
    assign have1      = (r.q_cnt != '0);
    assign have4      = (r.q_cnt == ctep_pkg::WORD_BYTES);

    // first control token among the held bytes, 1 based, 0 if none
    always_comb begin
        ct_pos = '0;
        for (int i = 3; i >= 0; i--) begin
            if ((3'(i) < r.q_cnt) && r.q_tag[i]) begin
                ct_pos = 3'(i + 1);
            end
        end
    end

    // while a block is counting only its own byte op is legal
    assign blk_ok = (r.blk_left == '0) ||
        (r.op == (r.blk_in ? ctep_pkg::OP_IN_BYTE : ctep_pkg::OP_OUT_BYTE));

    // next-state logic for the whole end
    always_comb begin
        n = r;
        n.rsp_valid = 1'b0;
        done  = 1'b0;
        exc   = 1'b0;
        dat   = '0;
        pop_n = '0;
        j     = 0;
        buf_ready = 1'b0;
        case (r.state)
            ctep_pkg::S_IDLE: begin
                if (cmd_valid) begin
                    n.op    = cmd_op;
                    n.arg   = cmd_data;
                    n.state = ctep_pkg::S_EXEC;
                end
            end
            ctep_pkg::S_EXEC: begin
                if (!blk_ok) begin
                    done = 1'b1;
                    exc  = 1'b1;
                end else begin
                    case (r.op)
                        ctep_pkg::OP_OUT_BYTE: begin
                            n.tx_sh   = {r.arg[7:0], 24'h000000};
                            n.tx_ctl  = 1'b0;
                            n.tx_left = ctep_pkg::ONE_BYTE;
                            n.state   = ctep_pkg::S_SEND;
                            if (r.blk_left != '0) begin
                                n.blk_left = r.blk_left - 1'b1;
                            end
                        end
                        ctep_pkg::OP_OUT_WORD: begin
                            // most significant byte goes first
                            n.tx_sh   = r.arg;
                            n.tx_ctl  = 1'b0;
                            n.tx_left = ctep_pkg::WORD_BYTES;
                            n.state   = ctep_pkg::S_SEND;
                        end
                        ctep_pkg::OP_OUT_CT: begin
                            if (r.arg[7:0] >= ctep_pkg::HW_TOKEN_MIN) begin
                                done = 1'b1;
                                exc  = 1'b1;
                            end else if (open &&
                                ((r.arg[7:0] == ctep_pkg::end_of_message_token) ||
                                 (r.arg[7:0] == ctep_pkg::route_pause_token))) begin
                                // refused so a stray token cannot drop the route
                                done = 1'b1;
                                exc  = 1'b1;
                            end else begin
                                n.tx_sh   = {r.arg[7:0], 24'h000000};
                                n.tx_ctl  = 1'b1;
                                n.tx_left = ctep_pkg::ONE_BYTE;
                                n.state   = ctep_pkg::S_SEND;
                            end
                        end
                        ctep_pkg::OP_MSG_END: begin
                            if (open) begin
                                done = 1'b1;
                                exc  = 1'b1;
                            end else begin
                                n.tx_sh   = {ctep_pkg::end_of_message_token, 24'h000000};
                                n.tx_ctl  = 1'b1;
                                n.tx_left = ctep_pkg::ONE_BYTE;
                                n.state   = ctep_pkg::S_SEND;
                            end
                        end
                        ctep_pkg::OP_IN_BYTE: begin
                            if (have1) begin
                                done = 1'b1;
                                if (r.q_tag[0]) begin
                                    exc = 1'b1;
                                end else begin
                                    dat   = {24'h000000, r.q_byte[0]};
                                    pop_n = ctep_pkg::ONE_BYTE;
                                    if (r.blk_left != '0) begin
                                        n.blk_left = r.blk_left - 1'b1;
                                    end
                                end
                            end
                        end
                        ctep_pkg::OP_IN_WORD: begin
                            if (ct_pos != '0) begin
                                done = 1'b1;
                                exc  = 1'b1;
                            end else if (have4) begin
                                done  = 1'b1;
                                dat   = r.q_byte;
                                pop_n = ctep_pkg::WORD_BYTES;
                            end
                        end
                        ctep_pkg::OP_IN_CT: begin
                            if (have1) begin
                                done = 1'b1;
                                if (r.q_tag[0]) begin
                                    dat   = {24'h000000, r.q_byte[0]};
                                    pop_n = ctep_pkg::ONE_BYTE;
                                end else begin
                                    exc = 1'b1;
                                end
                            end
                        end
                        ctep_pkg::OP_CHK_CT: begin
                            if (have1) begin
                                done = 1'b1;
                                if (r.q_tag[0] && (r.q_byte[0] == r.arg[7:0])) begin
                                    pop_n = ctep_pkg::ONE_BYTE;
                                end else begin
                                    exc = 1'b1;
                                end
                            end
                        end
                        ctep_pkg::OP_TEST_CT: begin
                            if (have1) begin
                                done = 1'b1;
                                dat  = {31'h00000000, r.q_tag[0]};
                            end
                        end
                        ctep_pkg::OP_TEST_WCT: begin
                            if ((ct_pos != '0) || have4) begin
                                done = 1'b1;
                                dat  = {29'h00000000, ct_pos};
                            end
                        end
                        ctep_pkg::OP_ST_MASTER: begin
                            if (open) begin
                                done = 1'b1;
                                exc  = 1'b1;
                            end else if (paths_free) begin
                                // waits here while every path is held
                                done         = 1'b1;
                                n.route      = ctep_pkg::R_OPEN;
                                n.role_slave = 1'b0;
                            end
                        end
                        ctep_pkg::OP_ST_SLAVE: begin
                            if (open) begin
                                done = 1'b1;
                                exc  = 1'b1;
                            end else if (peer_route_req) begin
                                done         = 1'b1;
                                n.route      = ctep_pkg::R_OPEN;
                                n.role_slave = 1'b1;
                            end
                        end
                        ctep_pkg::OP_SP_MASTER,
                        ctep_pkg::OP_SP_SLAVE: begin
                            done = 1'b1;
                            if (open &&
                                (r.role_slave == (r.op == ctep_pkg::OP_SP_SLAVE))) begin
                                n.route = ctep_pkg::R_CLOSED;
                            end else begin
                                exc = 1'b1;
                            end
                        end
                        ctep_pkg::OP_BLK_OUT,
                        ctep_pkg::OP_BLK_IN: begin
                            done       = 1'b1;
                            n.blk_left = r.arg[ctep_pkg::BLK_W-1:0];
                            n.blk_in   = (r.op == ctep_pkg::OP_BLK_IN);
                        end
                        default: begin
                            done = 1'b1;
                            exc  = 1'b1;
                        end
                    endcase
                end
            end
            ctep_pkg::S_SEND: begin
                if (tx_fire) begin
                    n.tx_sh   = {r.tx_sh[23:0], 8'h00};
                    n.tx_left = r.tx_left - ctep_pkg::ONE_BYTE;
                    if (r.tx_left == ctep_pkg::ONE_BYTE) begin
                        done = 1'b1;
                    end
                end
            end
            default: n.state = ctep_pkg::S_IDLE;
        endcase
        if (done) begin
            n.rsp_valid = 1'b1;
            n.rsp_exc   = exc;
            n.rsp_data  = exc ? 32'h00000000 : dat;
            n.state     = ctep_pkg::S_IDLE;
        end
        // drop consumed bytes, tags travel with them
        for (int i = 0; i < 4; i++) begin
            j = i + int'(pop_n);
            if (j < 4) begin
                n.q_byte[i] = r.q_byte[j[1:0]];
                n.q_tag[i]  = r.q_tag[j[1:0]];
            end else begin
                n.q_byte[i] = 8'h00;
                n.q_tag[i]  = 1'b0;
            end
        end
        n.q_cnt = r.q_cnt - pop_n;
        // refill in the same cycle so a word completes as fast as bytes come
        buf_ready = (n.q_cnt < ctep_pkg::WORD_BYTES);
        if (buf_ready && buf_valid) begin
            n.q_byte[n.q_cnt[1:0]] = buf_tok[7:0];
            n.q_tag[n.q_cnt[1:0]]  = buf_tok[8];
            n.q_cnt = n.q_cnt + ctep_pkg::ONE_BYTE;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    a_byte_ctrl_exc: assert property (
        (r.state == ctep_pkg::S_EXEC) && (r.op == ctep_pkg::OP_IN_BYTE) && blk_ok &&
        have1 && r.q_tag[0] |=> rsp_valid && rsp_exc)
        else $error("byte input over control token not refused");
    a_word_ctrl_exc: assert property (
        (r.state == ctep_pkg::S_EXEC) && (r.op == ctep_pkg::OP_IN_WORD) && blk_ok &&
        (ct_pos != '0) |=> rsp_valid && rsp_exc)
        else $error("word input over control token not refused");
    a_hw_token_out: assert property (
        (r.state == ctep_pkg::S_EXEC) && (r.op == ctep_pkg::OP_OUT_CT) && blk_ok &&
        (r.arg[7:0] >= ctep_pkg::HW_TOKEN_MIN) |=> rsp_exc && !tx_valid)
        else $error("hardware token was not refused");
    a_chk_match_ok: assert property (
        (r.state == ctep_pkg::S_EXEC) && (r.op == ctep_pkg::OP_CHK_CT) && blk_ok &&
        have1 && r.q_tag[0] && (r.q_byte[0] == r.arg[7:0]) |=> rsp_valid && !rsp_exc)
        else $error("matching check token refused");
    a_inct_data_exc: assert property (
        (r.state == ctep_pkg::S_EXEC) && (r.op == ctep_pkg::OP_IN_CT) && blk_ok &&
        have1 && !r.q_tag[0] |=> rsp_exc && (r.q_cnt >= $past(r.q_cnt)))
        else $error("token input on data not refused");
    a_test_no_drop: assert property (
        (r.state == ctep_pkg::S_EXEC) && (r.op == ctep_pkg::OP_TEST_CT) && blk_ok &&
        have1 |=> (rsp_data == {31'h00000000, $past(r.q_tag[0])}) &&
        (r.q_cnt >= $past(r.q_cnt)))
        else $error("byte test wrong or consumed data");
    a_testw_pos: assert property (
        (r.state == ctep_pkg::S_EXEC) && (r.op == ctep_pkg::OP_TEST_WCT) && blk_ok &&
        (ct_pos != '0) |=> rsp_valid && (rsp_data[2:0] == $past(ct_pos)))
        else $error("word test position wrong");
    a_master_open: assert property (
        (r.state == ctep_pkg::S_EXEC) && (r.op == ctep_pkg::OP_ST_MASTER) && blk_ok &&
        !open && paths_free |=> route_hold && rsp_valid ##1 route_hold)
        else $error("master start did not hold route");
    a_stop_release: assert property (
        $rose(rsp_valid) && !rsp_exc && $past(r.op == ctep_pkg::OP_SP_MASTER) |->
        !route_hold)
        else $error("stop left route held");
    a_paths_block: assert property (
        !route_hold && !paths_free |-> !tx_valid)
        else $error("traffic sent with all paths held");
endmodule

//--- tb/channel_end_token_port_tb.sv
// self-checking bench of the channel end token port
`timescale 1ns/1ns
module channel_end_token_port_tb;
    localparam logic [15:0] TILE = 16'h00A5; // arbitrary value
    localparam logic [7:0]  CORE = 8'h03;    // arbitrary value
    logic               clock, nrst, cmd_valid, slow, paths_free, peer_route_req, cmd_ready;
    logic               rsp_valid, rsp_exc, tx_valid, tx_ready, tx_ctrl, rx_valid, rx_ready;
    logic               rx_ctrl, route_hold, start_ready, word_ready;
    ctep_pkg::ctep_op_e cmd_op;
    logic [31:0]        cmd_data, rsp_data, r;
    logic [7:0]         tx_byte, rx_byte, core_id, seed;
    logic [15:0]        tile_id;
    logic [8:0]         toks[4];
    logic [8:0]         ex_q[$];
    int                 bad_count, compares;
    ctep_port #(.TILE_ID(TILE), .CORE_ID(CORE)) i_ctep_port (.clock(clock), .nrst(nrst),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data),
        .rsp_valid(rsp_valid), .rsp_exc(rsp_exc), .rsp_data(rsp_data), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_ctrl(tx_ctrl), .tx_byte(tx_byte), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .rx_ctrl(rx_ctrl), .rx_byte(rx_byte), .paths_free(paths_free),
        .peer_route_req(peer_route_req), .route_hold(route_hold), .start_ready(start_ready),
        .word_ready(word_ready), .tile_id(tile_id), .core_id(core_id));
    ctep_peer i_ctep_peer (.clock(clock), .slow(slow), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_ctrl(tx_ctrl), .tx_byte(tx_byte), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rx_ctrl(rx_ctrl), .rx_byte(rx_byte));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // expected word test answer: first control position, 0 when none
    function automatic logic [31:0] wct_pos(input logic [8:0] t[4]);
        for (int k = 0; k < 4; k++) if (t[k][8]) return 32'(k + 1);
        return 32'h0;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // one thread op: hold the request until taken, then wait for the answer
    task automatic op(input ctep_pkg::ctep_op_e o, input logic [31:0] d, input logic e,
                      output logic [31:0] res);
        int n = 0;
        @(negedge clock);
        cmd_valid = 1'b1;
        cmd_op = o;
        cmd_data = d;
        while (cmd_ready !== 1'b1 && n < 200) begin @(negedge clock); n++; end
        @(negedge clock);
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 400) begin @(negedge clock); n++; end
        if (n >= 400) begin bad_count++; complete_run(); end
        chk({31'h0, rsp_exc}, {31'h0, e});
        res = rsp_data;
    endtask
    // compare what the peer logged with what was expected on the link
    task automatic cmp_tx();
        chk(32'(i_ctep_peer.got_q.size()), 32'(ex_q.size()));
        foreach (ex_q[k]) chk({23'h0, i_ctep_peer.got_q[k]}, {23'h0, ex_q[k]});
        i_ctep_peer.got_q.delete();
        ex_q.delete();
    endtask
    initial begin clock = 1'b0; forever #10 clock = ~clock; end
    // main sequence
    initial begin
        {nrst, cmd_valid, slow, peer_route_req, cmd_data, paths_free} = 37'h1;
        cmd_op = ctep_pkg::OP_OUT_BYTE;
        seed = 8'h33;
        repeat (5) @(negedge clock);
        nrst = 1'b1;
        chk({16'h0, tile_id}, {16'h0, TILE});
        chk({24'h0, core_id}, {24'h0, CORE});
        slow = 1'b1;
        seed = lfsr(seed);
        ex_q = '{{1'b0, seed}, {1'b0, ~seed}, 9'h0A5, {1'b0, seed}, 9'h03C, 9'h110};
        op(ctep_pkg::OP_OUT_BYTE, {24'h0, seed}, 1'b0, r);
        op(ctep_pkg::OP_OUT_WORD, {~seed, 8'hA5, seed, 8'h3C}, 1'b0, r);
        op(ctep_pkg::OP_OUT_CT, 32'hC0, 1'b1, r);
        op(ctep_pkg::OP_OUT_CT, 32'h10, 1'b0, r);
        paths_free = 1'b0;
        fork
            op(ctep_pkg::OP_OUT_BYTE, 32'h77, 1'b0, r);
            begin
                repeat (10) @(negedge clock) chk({31'h0, tx_valid}, 32'h0);
                paths_free = 1'b1;
            end
        join
        ex_q.push_back(9'h077);
        cmp_tx();
        $display("test link output done");
        op(ctep_pkg::OP_ST_MASTER, 32'h0, 1'b0, r);
        chk({31'h0, route_hold}, 32'h1);
        op(ctep_pkg::OP_OUT_CT, {24'h0, ctep_pkg::end_of_message_token}, 1'b1, r);
        op(ctep_pkg::OP_OUT_CT, {24'h0, ctep_pkg::route_pause_token}, 1'b1, r);
        op(ctep_pkg::OP_MSG_END, 32'h0, 1'b1, r);
        op(ctep_pkg::OP_SP_SLAVE, 32'h0, 1'b1, r);
        op(ctep_pkg::OP_SP_MASTER, 32'h0, 1'b0, r);
        chk({31'h0, route_hold}, 32'h0);
        chk({31'h0, start_ready}, 32'h0);
        peer_route_req = 1'b1;
        @(negedge clock);
        chk({31'h0, start_ready}, 32'h1);
        op(ctep_pkg::OP_ST_SLAVE, 32'h0, 1'b0, r);
        chk({31'h0, route_hold}, 32'h1);
        peer_route_req = 1'b0;
        op(ctep_pkg::OP_SP_SLAVE, 32'h0, 1'b0, r);
        $display("test route done");
        op(ctep_pkg::OP_BLK_OUT, 32'h2, 1'b0, r);
        op(ctep_pkg::OP_OUT_CT, 32'h10, 1'b1, r);
        op(ctep_pkg::OP_OUT_BYTE, 32'h11, 1'b0, r);
        op(ctep_pkg::OP_OUT_BYTE, 32'h22, 1'b0, r);
        op(ctep_pkg::OP_MSG_END, 32'h0, 1'b0, r);
        ex_q = '{9'h011, 9'h022, {1'b1, ctep_pkg::end_of_message_token}};
        cmp_tx();
        $display("test block done");
        for (int p = 0; p <= 4; p++) begin
            chk({31'h0, word_ready}, 32'h0);
            for (int k = 0; k < 4; k++) begin
                seed = lfsr(seed);
                toks[k] = (k + 1 == p || p * k == 9) ? {1'b1, 8'h20 | 8'(k)} : {1'b0, seed};
                i_ctep_peer.send_q.push_back(toks[k]);
            end
            op(ctep_pkg::OP_TEST_WCT, 32'h0, 1'b0, r);
            chk(r, wct_pos(toks));
            chk({31'h0, word_ready}, 32'h1);
            op(ctep_pkg::OP_TEST_CT, 32'h0, 1'b0, r);
            chk(r, {31'h0, toks[0][8]});
            op(ctep_pkg::OP_IN_WORD, 32'h0, p != 0, r);
            if (p == 0) chk(r, {toks[3][7:0], toks[2][7:0], toks[1][7:0], toks[0][7:0]});
            for (int k = 0; k < 4 && p != 0; k++) begin
                if (toks[k][8]) begin
                    op(ctep_pkg::OP_IN_BYTE, 32'h0, 1'b1, r);
                    op(ctep_pkg::OP_CHK_CT, {24'h0, toks[k][7:0] ^ 8'h1}, 1'b1, r);
                    op(k[0] ? ctep_pkg::OP_CHK_CT : ctep_pkg::OP_IN_CT,
                       {24'h0, toks[k][7:0]}, 1'b0, r);
                    if (!k[0]) chk(r, {24'h0, toks[k][7:0]});
                end else begin
                    op(ctep_pkg::OP_IN_CT, 32'h0, 1'b1, r);
                    op(ctep_pkg::OP_IN_BYTE, 32'h0, 1'b0, r);
                    chk(r, {24'h0, toks[k][7:0]});
                end
            end
            $display("test receive pattern %0d done", p);
        end
        complete_run();
    end
endmodule

//--- tb/ctep_peer.sv
// peer channel end model: sends queued tokens, logs tokens it receives
`timescale 1ns/1ns
module ctep_peer (
    input  wire logic       clock,
    input  wire logic       slow,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    input  wire logic       tx_ctrl,
    input  wire logic [7:0] tx_byte,
    output logic            rx_valid,
    input  wire logic       rx_ready,
    output logic            rx_ctrl,
    output logic [7:0]      rx_byte
);
    logic [8:0] send_q[$];
    logic [8:0] got_q[$];
    initial begin
        tx_ready = 1'b1;
        rx_valid = 1'b0;
        rx_ctrl  = 1'b0;
        rx_byte  = 8'h00;
    end
    // drive at the falling edge; idle data line toggles so stale bytes never match
    always @(negedge clock) begin
        tx_ready <= slow ? !tx_ready : 1'b1;
        rx_valid <= send_q.size() != 0;
        if (send_q.size() != 0) begin
            {rx_ctrl, rx_byte} <= send_q[0];
        end else begin
            rx_byte <= ~rx_byte;
        end
    end
    // every handshake moves exactly one token, so counts match
    always @(posedge clock) begin
        if (rx_valid && rx_ready) begin
            void'(send_q.pop_front());
        end
        if (tx_valid && tx_ready) begin
            got_q.push_back({tx_ctrl, tx_byte});
        end
    end
endmodule
